/* File: src/sprx_clkgen.sv */
// glitch-free receive clock generator with two sources
`timescale 1ns/100ps
module sprx_clkgen #(
  parameter int HALF_CYC = 64,
  parameter int MIN_CYC = 58
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic useRecovered,
  input wire logic recRise,
  input wire logic recFall,
  output logic clkQ,
  output logic fallNow
);
  localparam int CW = $clog2(HALF_CYC + 1);

  logic [CW-1:0] widthQ;
  logic pendQ;
  logic reqRec;
  logic wide;
  logic tog;

  // every toggle waits out the least width, whichever source asks
  assign reqRec = (recRise && !clkQ) || (recFall && clkQ);
  assign wide = (widthQ >= CW'(MIN_CYC - 1));
  assign tog = useRecovered ? ((reqRec || pendQ) && wide)
                            : (widthQ == CW'(HALF_CYC - 1));
  assign fallNow = tog && clkQ;

  // ==========================================================================
  // width counter since the last toggle, also the nominal divider
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      widthQ <= '0;
    end else if (tog) begin
      widthQ <= '0;
    end else if (widthQ != CW'(HALF_CYC - 1)) begin
      widthQ <= widthQ + CW'(1);
    end
  end

  // a too-early recovered edge is deferred, not dropped
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pendQ <= 1'b0;
    end else if (!useRecovered || tog) begin
      pendQ <= 1'b0;
    end else if (reqRec) begin
      pendQ <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      clkQ <= 1'b0;
    end else if (tog) begin
      clkQ <= !clkQ;
    end
  end

endmodule : sprx_clkgen

/* File: src/sprx_deser.sv */
// deserializer and lock detector for the sampled serial line
`timescale 1ns/100ps
module sprx_deser #(
  parameter int WORD_W = 16,
  parameter int LOCK_EDGES = 32,
  parameter int ACT_TIMEOUT = 32
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic bitStrobe,
  input wire logic lineBit,
  input wire logic signalLost,
  input wire logic syncFault,
  output logic [WORD_W-1:0] wordQ,
  output logic wordDoneQ,
  output logic midWordQ,
  output logic lockedQ
);
  localparam int BW = $clog2(WORD_W);
  localparam int EW = $clog2(LOCK_EDGES + 1);
  localparam int IW = $clog2(ACT_TIMEOUT + 1);

  logic [WORD_W-1:0] shiftQ;
  logic [BW-1:0] bitCntQ;
  logic [EW-1:0] edgeCntQ;
  logic [IW-1:0] idleCntQ;
  logic lastBit;
  logic badLine;

  assign lastBit = (bitCntQ == BW'(WORD_W - 1));
  assign badLine = signalLost || syncFault || (idleCntQ == IW'(ACT_TIMEOUT));

  // ==========================================================================
  // shift, earliest bit ends in the top bit
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      shiftQ <= '0;
      bitCntQ <= '0;
      wordQ <= '0;
    end else if (bitStrobe) begin
      shiftQ <= {shiftQ[WORD_W-2:0], lineBit};
      bitCntQ <= lastBit ? '0 : bitCntQ + BW'(1);
      if (lastBit) begin
        wordQ <= {shiftQ[WORD_W-2:0], lineBit};
      end
    end
  end

  // phase marks for the recovered word clock
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wordDoneQ <= 1'b0;
      midWordQ <= 1'b0;
    end else begin
      wordDoneQ <= bitStrobe && lastBit;
      midWordQ <= bitStrobe && (bitCntQ == BW'(WORD_W / 2 - 1));
    end
  end

  // ==========================================================================
  // lock: enough steady edges and no fault; any fault drops it at once
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      idleCntQ <= '0;
    end else if (bitStrobe) begin
      idleCntQ <= '0;
    end else if (idleCntQ != IW'(ACT_TIMEOUT)) begin
      idleCntQ <= idleCntQ + IW'(1);
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      edgeCntQ <= '0;
      lockedQ <= 1'b0;
    end else if (badLine) begin
      edgeCntQ <= '0;
      lockedQ <= 1'b0;
    end else begin
      if (bitStrobe && edgeCntQ != EW'(LOCK_EDGES)) begin
        edgeCntQ <= edgeCntQ + EW'(1);
      end
      lockedQ <= (edgeCntQ == EW'(LOCK_EDGES));
    end
  end

endmodule : sprx_deser

/* File: src/sprx_pkg.sv */
// shared constants and types for the serial receive clock and loopback block
package sprx_pkg;

  // ==========================================================================
  // data path
  localparam int WORD_W = 16;

  // ==========================================================================
  // timing
  // the receive clock is a scaled model: one word period is 16 line bits
  localparam int SYS_CLK_KHZ = 25000;
  localparam int LINE_BIT_NS = 320;
  localparam int NOM_PERIOD_NS = LINE_BIT_NS * WORD_W;
  localparam int NOM_HALF_CYC = (NOM_PERIOD_NS * SYS_CLK_KHZ) / (2 * 1000000);
  localparam int MIN_DUTY_PCT = 45;
  // least pulse width, rounded up to whole cycles
  localparam int MIN_PULSE_CYC =
    (NOM_PERIOD_NS * MIN_DUTY_PCT * (SYS_CLK_KHZ / 1000) + 100000 - 1) / 100000;
  // tolerance of the substitute clock in ppm; the local divider is exact
  localparam int NOM_TOL_PPM = 2500;
  localparam int LOCK_EDGES_DEF = 32;
  localparam int ACT_TIMEOUT_CYC = 32;

  // ==========================================================================
  // register map
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLR = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 8'h10;

  localparam int CTRL_LOOP_BIT = 0;
  localparam logic CTRL_LOOP_RST = 1'b0;

  localparam int ST_LOCKED_BIT = 0;
  localparam int ST_RECOVERED_BIT = 1;
  localparam int ST_NOSIG_BIT = 2;
  localparam int ST_SYNCERR_BIT = 3;
  localparam int ST_LOOP_BIT = 4;

  localparam int IRQ_W = 4;
  localparam int IRQ_LOCK_GAIN_BIT = 0;
  localparam int IRQ_LOCK_LOSS_BIT = 1;
  localparam int IRQ_NOSIG_BIT = 2;
  localparam int IRQ_SYNCERR_BIT = 3;
  localparam logic [IRQ_W-1:0] IRQ_EN_RST = 4'h0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    REG_CTRL,
    REG_STATUS,
    REG_IRQ_STAT,
    REG_IRQ_CLR,
    REG_IRQ_EN,
    REG_NONE
  } sprx_reg_e;

endpackage : sprx_pkg

/* File: src/sprx_top.sv */
// receive clock selection, loopback and register slave of the serial receiver
// Function
// - receive clock recovered from serial stream when possible
// - fault or no signal: keep valid substitute clock
// - switchover pulses never below nominal period times 45%
// - least pulse width unchanged across source change
// - loopback bit one enters, zero leaves loopback
// - loopback routes transmit data, ignores line input
// - loopback only on explicit request, never default
// - first received bit lands in bit 15
`timescale 1ns/100ps
module sprx_top #(
  parameter int WORD_W = sprx_pkg::WORD_W,
  parameter int LOCK_EDGES = sprx_pkg::LOCK_EDGES_DEF,
  parameter int ACT_TIMEOUT = sprx_pkg::ACT_TIMEOUT_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic linkClk,
  input wire logic lineData,
  input wire logic noInputSignal,
  input wire logic syncError,
  input wire logic [WORD_W-1:0] txData,
  input wire logic txValid,
  output logic recoveredRxClock,
  output logic [WORD_W-1:0] rxData,
  output logic lineSignalValid,
  output logic irq,
  input wire logic [sprx_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [sprx_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int NSYNC = 4;
  localparam int IW = sprx_pkg::IRQ_W;

  // ==========================================================================
  // address decode, shared by read and write
  function automatic sprx_pkg::sprx_reg_e sprxDecode(input logic [sprx_pkg::ADDR_W-1:0] a);
    sprx_pkg::sprx_reg_e r;
    r = sprx_pkg::REG_NONE;
    case (a)
      sprx_pkg::OFS_CTRL: r = sprx_pkg::REG_CTRL;
      sprx_pkg::OFS_STATUS: r = sprx_pkg::REG_STATUS;
      sprx_pkg::OFS_IRQ_STAT: r = sprx_pkg::REG_IRQ_STAT;
      sprx_pkg::OFS_IRQ_CLR: r = sprx_pkg::REG_IRQ_CLR;
      sprx_pkg::OFS_IRQ_EN: r = sprx_pkg::REG_IRQ_EN;
      default: r = sprx_pkg::REG_NONE;
    endcase
    return r;
  endfunction : sprxDecode

  // ==========================================================================
  // pin synchronisers
  logic [NSYNC-1:0] asyncIn;
  logic [NSYNC-1:0] sync1Q;
  logic [NSYNC-1:0] sync2Q;
  logic linkPrevQ;
  logic linkRise;
  logic sigLostS;
  logic syncErrS;

  assign asyncIn = {syncError, noInputSignal, lineData, linkClk};
  assign sigLostS = sync2Q[2];
  assign syncErrS = sync2Q[3];

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sync1Q <= '0;
      sync2Q <= '0;
    end else begin
      sync1Q <= asyncIn;
      sync2Q <= sync1Q;
    end
  end

  // line data is taken on the rising link edge after both have crossed
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      linkPrevQ <= 1'b0;
    end else begin
      linkPrevQ <= sync2Q[0];
    end
  end

  assign linkRise = sync2Q[0] && !linkPrevQ;

  // ==========================================================================
  // deserializer and lock
  logic [WORD_W-1:0] lineWord;
  logic wordDone;
  logic midWord;
  logic locked;
  logic loopQ;
  logic useRecovered;

  sprx_deser #(
    .WORD_W(WORD_W),
    .LOCK_EDGES(LOCK_EDGES),
    .ACT_TIMEOUT(ACT_TIMEOUT)
  ) u_deser (
    .sys_clk(sys_clk),
    .rst(rst),
    .bitStrobe(linkRise),
    .lineBit(sync2Q[1]),
    .signalLost(sigLostS),
    .syncFault(syncErrS),
    .wordQ(lineWord),
    .wordDoneQ(wordDone),
    .midWordQ(midWord),
    .lockedQ(locked)
  );

  // in loopback the line is ignored, so the local clock paces the words
  assign useRecovered = locked && !loopQ;
  assign lineSignalValid = locked;

  // ==========================================================================
  // receive clock
  logic fallNow;

  sprx_clkgen #(
    .HALF_CYC(sprx_pkg::NOM_HALF_CYC),
    .MIN_CYC(sprx_pkg::MIN_PULSE_CYC)
  ) u_clkgen (
    .sys_clk(sys_clk),
    .rst(rst),
    .useRecovered(useRecovered),
    .recRise(midWord),
    .recFall(wordDone),
    .clkQ(recoveredRxClock),
    .fallNow(fallNow)
  );

  // ==========================================================================
  // receive data: changes only with the falling clock, stable at the rise
  logic [WORD_W-1:0] txWordQ;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      txWordQ <= '0;
    end else if (txValid) begin
      txWordQ <= txData;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rxData <= '0;
    end else if (fallNow) begin
      rxData <= loopQ ? txWordQ : lineWord;
    end
  end

  // ==========================================================================
  // write channels, taken in either order
  logic awHeldQ;
  logic wHeldQ;
  logic [sprx_pkg::ADDR_W-1:0] awAddrQ;
  logic [31:0] wDataQ;
  logic [3:0] wStrbQ;
  logic doWrite;
  sprx_pkg::sprx_reg_e wrReg;

  assign doWrite = awHeldQ && wHeldQ && !s_axi_bvalid;
  assign wrReg = sprxDecode(awAddrQ);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      awHeldQ <= 1'b0;
      awAddrQ <= '0;
    end else if (s_axi_awready && s_axi_awvalid) begin
      s_axi_awready <= 1'b0;
      awHeldQ <= 1'b1;
      awAddrQ <= s_axi_awaddr;
    end else begin
      if (doWrite) begin
        awHeldQ <= 1'b0;
      end
      s_axi_awready <= !awHeldQ && !s_axi_bvalid;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_axi_wready <= 1'b0;
      wHeldQ <= 1'b0;
      wDataQ <= '0;
      wStrbQ <= '0;
    end else if (s_axi_wready && s_axi_wvalid) begin
      s_axi_wready <= 1'b0;
      wHeldQ <= 1'b1;
      wDataQ <= s_axi_wdata;
      wStrbQ <= s_axi_wstrb;
    end else begin
      if (doWrite) begin
        wHeldQ <= 1'b0;
      end
      s_axi_wready <= !wHeldQ && !s_axi_bvalid;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= sprx_pkg::RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wrReg == sprx_pkg::REG_NONE) ? sprx_pkg::RESP_SLVERR
                                                   : sprx_pkg::RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // control and interrupt registers
  logic [IW-1:0] irqStatQ;
  logic [IW-1:0] irqEnQ;
  logic [IW-1:0] irqEvt;
  logic [IW-1:0] irqClr;
  logic [IW-1:0] irqStatD;
  logic lockedPrevQ;
  logic sigLostPrevQ;
  logic syncErrPrevQ;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      loopQ <= sprx_pkg::CTRL_LOOP_RST;
    end else if (doWrite && wrReg == sprx_pkg::REG_CTRL && wStrbQ[0]) begin
      loopQ <= wDataQ[sprx_pkg::CTRL_LOOP_BIT];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irqEnQ <= sprx_pkg::IRQ_EN_RST;
    end else if (doWrite && wrReg == sprx_pkg::REG_IRQ_EN && wStrbQ[0]) begin
      irqEnQ <= wDataQ[IW-1:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lockedPrevQ <= 1'b0;
      sigLostPrevQ <= 1'b0;
      syncErrPrevQ <= 1'b0;
    end else begin
      lockedPrevQ <= locked;
      sigLostPrevQ <= sigLostS;
      syncErrPrevQ <= syncErrS;
    end
  end

  always_comb begin
    irqEvt = '0;
    irqEvt[sprx_pkg::IRQ_LOCK_GAIN_BIT] = locked && !lockedPrevQ;
    irqEvt[sprx_pkg::IRQ_LOCK_LOSS_BIT] = !locked && lockedPrevQ;
    irqEvt[sprx_pkg::IRQ_NOSIG_BIT] = sigLostS && !sigLostPrevQ;
    irqEvt[sprx_pkg::IRQ_SYNCERR_BIT] = syncErrS && !syncErrPrevQ;
    irqClr = '0;
    if (doWrite && wrReg == sprx_pkg::REG_IRQ_CLR && wStrbQ[0]) begin
      irqClr = wDataQ[IW-1:0];
    end
    // a new event outranks a clear in the same cycle
    irqStatD = (irqStatQ & ~irqClr) | irqEvt;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irqStatQ <= '0;
      irq <= 1'b0;
    end else begin
      irqStatQ <= irqStatD;
      irq <= |(irqStatD & irqEnQ);
    end
  end

  // ==========================================================================
  // read channel
  logic [31:0] rdMux;
  sprx_pkg::sprx_reg_e rdReg;

  assign rdReg = sprxDecode(s_axi_araddr);

  always_comb begin
    rdMux = '0;
    case (rdReg)
      sprx_pkg::REG_CTRL: rdMux[sprx_pkg::CTRL_LOOP_BIT] = loopQ;
      sprx_pkg::REG_STATUS: begin
        rdMux[sprx_pkg::ST_LOCKED_BIT] = locked;
        rdMux[sprx_pkg::ST_RECOVERED_BIT] = useRecovered;
        rdMux[sprx_pkg::ST_NOSIG_BIT] = sigLostS;
        rdMux[sprx_pkg::ST_SYNCERR_BIT] = syncErrS;
        rdMux[sprx_pkg::ST_LOOP_BIT] = loopQ;
      end
      sprx_pkg::REG_IRQ_STAT: rdMux[IW-1:0] = irqStatQ;
      sprx_pkg::REG_IRQ_EN: rdMux[IW-1:0] = irqEnQ;
      default: rdMux = '0;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= sprx_pkg::RESP_OKAY;
    end else if (s_axi_arready && s_axi_arvalid) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdMux;
      s_axi_rresp <= (rdReg == sprx_pkg::REG_NONE) ? sprx_pkg::RESP_SLVERR
                                                   : sprx_pkg::RESP_OKAY;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule : sprx_top

/* File: verif/sprx_client_model.sv */
// receive client model: records every word captured on the receive clock
`timescale 1ns/100ps
module sprx_client_model (
  input wire logic rxClk,
  input wire logic [sprx_pkg::WORD_W-1:0] rxData
);
  logic [sprx_pkg::WORD_W-1:0] hist[$];
  always @(posedge rxClk) begin
    hist.push_back(rxData);
  end
endmodule : sprx_client_model

/* File: verif/sprx_top_properties.sv */
// concurrent checks on the receive clock, receive data and register bus ports
`timescale 1ns/100ps
module sprx_top_properties #(
  parameter int WORD_W = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic noInputSignal,
  input wire logic syncError,
  input wire logic recoveredRxClock,
  input wire logic [WORD_W-1:0] rxData,
  input wire logic lineSignalValid,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int HALF = sprx_pkg::NOM_HALF_CYC;
  logic prevClk_q;
  logic [7:0] segCnt_q;
  logic everLocked_q;
  // ==========================================================================
  // helper logic
  // saturated at reset so the first pulse after release is not misjudged
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prevClk_q <= 1'h0;
      segCnt_q <= 8'hFF;
    end else begin
      prevClk_q <= recoveredRxClock;
      if (recoveredRxClock != prevClk_q) begin
        segCnt_q <= 8'h01;
      end else if (segCnt_q != 8'hFF) begin
        segCnt_q <= segCnt_q + 8'h01;
      end
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      everLocked_q <= 1'h0;
    end else if (lineSignalValid) begin
      everLocked_q <= 1'h1;
    end
  end
  // ==========================================================================
  // assertions
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  min_pulse_a: assert property (recoveredRxClock != prevClk_q
    |-> segCnt_q >= 8'(sprx_pkg::MIN_PULSE_CYC)) else $error("receive clock pulse too short");
  clock_alive_a: assert property ($changed(recoveredRxClock)
    |-> ##[1:300] $changed(recoveredRxClock)) else $error("receive clock stopped");
  nominal_half_a: assert property (!everLocked_q && $changed(recoveredRxClock)
    |-> ##HALF ($changed(recoveredRxClock) || lineSignalValid)) else $error("nominal half wrong");
  rx_data_stable_a: assert property ($changed(rxData) |-> !recoveredRxClock)
    else $error("receive data moved while clock high");
  nosig_unlock_a: assert property ($rose(noInputSignal) |-> ##[1:6] !lineSignalValid)
    else $error("lock kept without signal");
  sync_unlock_a: assert property ($rose(syncError) |-> ##[1:6] !lineSignalValid)
    else $error("lock kept on sync error");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write answer late");
  // the master keeps its ready up, so the answer must retire after one taken edge
  bresp_hold_a: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer not retired");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  rdata_hold_a: assert property (s_axi_rvalid && s_axi_rready
    |=> !s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer not retired");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while answer pending");
  lock_seen_c: cover property ($rose(lineSignalValid));
  recovered_edge_c: cover property ($fell(recoveredRxClock) && lineSignalValid);
  slverr_c: cover property (s_axi_bvalid && s_axi_bresp == sprx_pkg::RESP_SLVERR);
endmodule : sprx_top_properties

/* File: verif/sprx_top_tb.sv */
// self-checking bench for the receive clock and loopback block
`timescale 1ns/100ps
module sprx_top_tb;
  logic sys_clk = 1'h0, rst = 1'h1, linkClk = 1'h0, lineData = 1'h0;
  logic noInputSignal = 1'h0, syncError = 1'h0, txValid = 1'h0;
  logic [15:0] txData = 16'h0000, rxData;
  logic recoveredRxClock, lineSignalValid, irq;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  int errors = 0, num_checks = 0;
  sprx_top i_dut (.sys_clk, .rst, .linkClk, .lineData, .noInputSignal, .syncError,
    .txData, .txValid, .recoveredRxClock, .rxData, .lineSignalValid, .irq,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  sprx_client_model i_client (.rxClk(recoveredRxClock), .rxData(rxData));
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  // ==========================================================================
  // tasks
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) break;
    end
    rs = s_axi_bresp;
    s_axi_bready <= 1'h0;
    if (n == 50) errors++;
  endtask : axiWrite
  task automatic axiRead(input logic [7:0] a);
    int n;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) break;
    end
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'h0;
    if (n == 50) errors++;
  endtask : axiRead
  // line bits change while the link clock is low; the link stands still between words
  task automatic sendWord(input logic [15:0] w);
    @(posedge sys_clk);
    for (int b = 15; b >= 0; b--) begin
      lineData <= w[b];
      repeat (4) @(posedge sys_clk);
      linkClk <= 1'h1;
      repeat (4) @(posedge sys_clk);
      linkClk <= 1'h0;
    end
    lineData <= ~w[0];
  endtask : sendWord
  task automatic waitRise;
    int n;
    n = 0;
    while (recoveredRxClock !== 1'h0 && n < 400) begin
      @(posedge sys_clk);
      n++;
    end
    while (recoveredRxClock !== 1'h1 && n < 400) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 400) errors++;
  endtask : waitRise
  function automatic logic [15:0] word(input int f, input int k);
    return 16'hC0A1 ^ 16'(k * 16'h1357) ^ 16'(f << 8);
  endfunction : word
  function automatic logic found(input logic [15:0] w);
    foreach (i_client.hist[k]) if (i_client.hist[k] === w) return 1'h1;
    return 1'h0;
  endfunction : found
  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test
  // ==========================================================================
  // tests
  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'h0;
    axiRead(sprx_pkg::OFS_CTRL);
    chk("ctrl reset", rd, 32'h0);
    axiRead(sprx_pkg::OFS_IRQ_EN);
    chk("irq enable reset", rd, 32'h0);
    axiRead(sprx_pkg::OFS_STATUS);
    chk("status reset", rd, 32'h0);
    axiRead(8'h40);
    chk("unmapped read resp", 32'(rs), 32'(sprx_pkg::RESP_SLVERR));
    chk("unmapped read data", rd, 32'h0);
    axiWrite(8'h40, 32'h1);
    chk("unmapped write resp", 32'(rs), 32'(sprx_pkg::RESP_SLVERR));
    // pass 0: signal lost with irq enabled, pass 1: sync error with irq masked
    for (int f = 0; f < 2; f++) begin
      axiWrite(sprx_pkg::OFS_IRQ_EN, (f == 0) ? 32'h1 : 32'h0);
      for (int k = 0; k < 6; k++) sendWord(word(f, k));
      chk("locked", 32'(lineSignalValid), 32'h1);
      axiRead(sprx_pkg::OFS_STATUS);
      chk("recovered in use", rd, 32'h3);
      chk("word 3 order", 32'(found(word(f, 3))), 32'h1);
      chk("word 4 order", 32'(found(word(f, 4))), 32'h1);
      chk("irq level", 32'(irq), (f == 0) ? 32'h1 : 32'h0);
      if (f == 0) noInputSignal <= 1'h1;
      else syncError <= 1'h1;
      repeat (8) @(posedge sys_clk);
      chk("unlocked", 32'(lineSignalValid), 32'h0);
      axiRead(sprx_pkg::OFS_IRQ_STAT);
      chk("irq status", rd, 32'(4'h3 | 4'(4 << f)));
      axiWrite(sprx_pkg::OFS_IRQ_CLR, 32'hF);
      axiRead(sprx_pkg::OFS_IRQ_STAT);
      chk("irq cleared", rd, 32'h0);
      chk("irq low", 32'(irq), 32'h0);
      noInputSignal <= 1'h0;
      syncError <= 1'h0;
      repeat (8) @(posedge sys_clk);
    end
    axiWrite(sprx_pkg::OFS_CTRL, 32'h1);
    axiRead(sprx_pkg::OFS_STATUS);
    chk("loop on", 32'(rd[4]), 32'h1);
    chk("nominal in loop", 32'(rd[1]), 32'h0);
    txData <= 16'h5AF0;
    txValid <= 1'h1;
    @(posedge sys_clk);
    txValid <= 1'h0;
    fork
      // enough line edges to lock, yet the recovered source must stay unused
      for (int k = 0; k < 3; k++) sendWord(16'h0F0F);
      begin
        waitRise;
        waitRise;
      end
    join
    chk("loop word", 32'(i_client.hist[$]), 32'h5AF0);
    axiRead(sprx_pkg::OFS_STATUS);
    chk("line ignored in loop", rd, 32'h11);
    axiWrite(sprx_pkg::OFS_CTRL, 32'h0);
    axiRead(sprx_pkg::OFS_STATUS);
    chk("loop off", 32'(rd[4]), 32'h0);
    stop_test();
  end
  // about 2100 cycles are needed; allow a wide margin
  initial begin
    #400000;
    errors++;
    stop_test();
  end
endmodule : sprx_top_tb
bind sprx_top sprx_top_properties #(.WORD_W(WORD_W)) i_props (.sys_clk, .rst,
  .noInputSignal, .syncError, .recoveredRxClock, .rxData, .lineSignalValid,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready);
